// file: src/tpc_pkg.sv
// Shared constants, field layouts and carrier types of the timer, PWM and capture unit.
// Assumes a byte-addressed register port with 32-bit data and one clock per domain.
package tpc_pkg;

    localparam int TPC_NCH = 6;
    localparam int TPC_CNT_W = 16;
    localparam int TPC_PRE_W = 7;

    localparam logic [7:0] TPC_ADDR_SC = 8'h00;
    localparam logic [7:0] TPC_ADDR_CNT = 8'h04;
    localparam logic [7:0] TPC_ADDR_MOD = 8'h08;
    localparam logic [7:0] TPC_ADDR_STATUS = 8'h0C;
    localparam logic [7:0] TPC_ADDR_CH_BASE = 8'h10;
    localparam int TPC_CH_SHIFT = 3;
    localparam int TPC_CH_VAL_BIT = 2;

    localparam int TPC_SC_PS_LSB = 0;
    localparam int TPC_SC_CLOCK_SOURCE_SELECT_LSB = 3;
    localparam int TPC_SC_CENTER_ALIGN_SELECT_BIT = 5;
    localparam int TPC_SC_OVERFLOW_IRQ_ENABLE_BIT = 6;
    localparam int TPC_SC_TOF_BIT = 7;
    localparam int TPC_CH_ELS_LSB = 0;
    localparam int TPC_CH_FN_LSB = 2;
    localparam int TPC_CH_IE_BIT = 6;
    localparam int TPC_CH_FLAG_BIT = 7;
    localparam int TPC_STATUS_TOF_BIT = 8;

    localparam logic [1:0] TPC_CLK_OFF = 2'h0;
    localparam logic [1:0] TPC_CLK_CNT = 2'h1;
    localparam logic [1:0] TPC_CLK_EXT = 2'h2;
    localparam logic [1:0] TPC_FN_CAPTURE = 2'h0;
    localparam logic [1:0] TPC_FN_COMPARE = 2'h1;
    localparam logic [1:0] TPC_FN_PWM = 2'h2;
    localparam logic [1:0] TPC_ELS_NONE = 2'h0;
    localparam logic [1:0] TPC_ELS_TOGGLE = 2'h1;
    localparam logic [1:0] TPC_ELS_CLEAR = 2'h2;
    localparam logic [1:0] TPC_ELS_SET = 2'h3;

    localparam logic [15:0] TPC_LIMIT_RST = 16'h0000;
    localparam logic [15:0] TPC_VALUE_RST = 16'h0000;

    typedef enum logic {TPC_DIR_UP, TPC_DIR_DOWN} tpc_dir_e;

    typedef struct packed {
        logic irq_en;
        logic [1:0] fn;
        logic [1:0] els;
    } tpc_chan_ctrl_s;

    typedef struct packed {
        logic [1:0] clk_src;
        logic [2:0] ps;
        logic center;
        logic [15:0] limit;
    } tpc_cfg_s;

endpackage

// file: src/tpc_sync.sv
// Two-stage synchroniser for a bundle of levels.
// Assumes each bit is a level or a toggle that stands for several destination cycles.
`timescale 1ns/1ps
module tpc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// file: src/tpc_timer.sv
// Assumes a simple register port in the bus domain and channel pins in the counter domain.
`timescale 1ns/1ps
module tpc_timer #(
    parameter int NCH = tpc_pkg::TPC_NCH
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_cnt,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ext_clk_pin,
    input wire logic [NCH-1:0] channel_pin_in,
    output logic [NCH-1:0] channel_pin_out,
    output logic [NCH-1:0] channel_pin_oe_n,
    output logic overflow_irq,
    output logic [NCH-1:0] channel_irq
);
    import tpc_pkg::*;

    localparam int TC_W = $bits(tpc_cfg_s) + NCH * $bits(tpc_chan_ctrl_s) + NCH * 16 + 2 + NCH;
    localparam int TB_W = 16 + 2 + 1 + NCH;

    // Bus clock domain state.
    logic [1:0] clock_source_select_reg;
    logic [2:0] prescale_select_reg;
    logic center_align_select_reg;
    logic overflow_irq_enable_reg;
    logic overflow_flag_reg;
    logic [15:0] period_limit_reg;
    logic cnt_wr_tog_reg;
    logic [NCH:0] evt_seen_reg;
    logic [31:0] rdata_reg;
    logic ovf_irq_reg;

    // Counter clock domain state.
    logic [TPC_PRE_W-1:0] pre_reg;
    logic [15:0] cnt_reg;
    tpc_dir_e dir_reg;
    logic [15:0] act_lim_reg;
    logic ext_prev_reg;
    logic wr_prev_reg;
    logic ovf_tog_reg;

    tpc_chan_ctrl_s [NCH-1:0] chc_w;
    logic [NCH-1:0][15:0] cv_w;
    logic [NCH-1:0] chf_w;
    logic [NCH-1:0] ch_tog_w;
    logic [NCH-1:0] irq_w;
    logic [NCH-1:0] out_w;
    logic [NCH-1:0] oe_n_w;

    tpc_cfg_s cfg_w;
    tpc_cfg_s cfg_q;
    tpc_chan_ctrl_s [NCH-1:0] chc_q;
    logic [NCH-1:0][15:0] cv_q;
    logic wr_tog_q;
    logic ext_q;
    logic [NCH-1:0] pin_q;
    logic [TC_W-1:0] to_cnt_q;
    logic [TB_W-1:0] to_bus_q;
    logic [15:0] cnt_bus_q;
    logic [1:0] clk_src_back_q;
    logic [NCH:0] evt_q;

    // Configuration is crossed as quasi-static levels; software should not rewrite it
    // in the same few counter cycles in which it relies on a consistent multi-bit value.
    assign cfg_w = '{clk_src: clock_source_select_reg, ps: prescale_select_reg,
                     center: center_align_select_reg, limit: period_limit_reg};

    tpc_sync #(.W(TC_W)) u_to_cnt (
        .clk(clk_cnt),
        .rst(rst),
        .d({cfg_w, chc_w, cv_w, cnt_wr_tog_reg, ext_clk_pin, channel_pin_in}),
        .q(to_cnt_q)
    );
    assign {cfg_q, chc_q, cv_q, wr_tog_q, ext_q, pin_q} = to_cnt_q;

    tpc_sync #(.W(TB_W)) u_to_bus (
        .clk(clk_sys),
        .rst(rst),
        .d({cnt_reg, cfg_q.clk_src, ovf_tog_reg, ch_tog_w}),
        .q(to_bus_q)
    );
    assign {cnt_bus_q, clk_src_back_q, evt_q} = to_bus_q;

    // Register decode.
    logic sel_sc, sel_cnt, sel_mod, sel_status, ch_hit, ch_is_val, ovf_ev, ovf_clr;
    logic [7:0] ch_ofs, ch_idx;
    logic [1:0] clock_source_select_read;
    logic [31:0] ch_rd_word, rd_next;

    assign sel_sc = reg_addr == TPC_ADDR_SC;
    assign sel_cnt = reg_addr == TPC_ADDR_CNT;
    assign sel_mod = reg_addr == TPC_ADDR_MOD;
    assign sel_status = reg_addr == TPC_ADDR_STATUS;
    assign ch_ofs = reg_addr - TPC_ADDR_CH_BASE;
    assign ch_idx = ch_ofs >> TPC_CH_SHIFT;
    assign ch_hit = (reg_addr >= TPC_ADDR_CH_BASE) && (ch_idx < 8'(NCH)) && (ch_ofs[1:0] == 2'h0);
    assign ch_is_val = ch_ofs[TPC_CH_VAL_BIT];
    assign ovf_ev = evt_q[NCH] ^ evt_seen_reg[NCH];
    assign ovf_clr = reg_wr && ((sel_sc && reg_wdata[TPC_SC_TOF_BIT])
                     || (sel_status && reg_wdata[TPC_STATUS_TOF_BIT]));
    // The field holds its old reading until the counter side has seen the stop.
    assign clock_source_select_read = (clock_source_select_reg == TPC_CLK_OFF) ? clk_src_back_q
                     : clock_source_select_reg;
    assign ch_rd_word = !ch_hit ? 32'h0000_0000
                      : ch_is_val ? {16'h0000, cv_w[ch_idx[2:0]]}
                      : {24'h00_0000, chf_w[ch_idx[2:0]], chc_w[ch_idx[2:0]].irq_en, 2'h0,
                         chc_w[ch_idx[2:0]].fn, chc_w[ch_idx[2:0]].els};
    assign rd_next = sel_sc ? {24'h00_0000, overflow_flag_reg, overflow_irq_enable_reg,
                               center_align_select_reg, clock_source_select_read, prescale_select_reg}
                   : sel_cnt ? {16'h0000, cnt_bus_q}
                   : sel_mod ? {16'h0000, period_limit_reg}
                   : sel_status ? {23'h00_0000, overflow_flag_reg, {(8 - NCH){1'b0}}, chf_w}
                   : ch_rd_word;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clock_source_select_reg <= TPC_CLK_OFF;
            prescale_select_reg <= 3'h0;
            center_align_select_reg <= 1'b0;
            overflow_irq_enable_reg <= 1'b0;
            period_limit_reg <= TPC_LIMIT_RST;
            cnt_wr_tog_reg <= 1'b0;
        end else if (reg_wr && sel_sc) begin
            prescale_select_reg <= reg_wdata[TPC_SC_PS_LSB +: 3];
            clock_source_select_reg <= reg_wdata[TPC_SC_CLOCK_SOURCE_SELECT_LSB +: 2];
            center_align_select_reg <= reg_wdata[TPC_SC_CENTER_ALIGN_SELECT_BIT];
            overflow_irq_enable_reg <= reg_wdata[TPC_SC_OVERFLOW_IRQ_ENABLE_BIT];
        end else if (reg_wr && sel_mod) begin
            period_limit_reg <= reg_wdata[15:0];
        end else if (reg_wr && sel_cnt) begin
            cnt_wr_tog_reg <= ~cnt_wr_tog_reg;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            overflow_flag_reg <= 1'b0;
            ovf_irq_reg <= 1'b0;
            evt_seen_reg <= '0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            // A new overflow beats a clear in the same cycle.
            overflow_flag_reg <= ovf_ev | (overflow_flag_reg & ~ovf_clr);
            ovf_irq_reg <= overflow_flag_reg & overflow_irq_enable_reg;
            evt_seen_reg <= evt_q;
            rdata_reg <= reg_rd ? rd_next : 32'h0000_0000;
        end
    end

    assign reg_rdata = rdata_reg;
    assign overflow_irq = ovf_irq_reg;

    // Counter domain: clock source, prescaler and counter.
    logic running, ext_rise, src_tick, tick, cnt_wr, at_lim, wrap, turn, bottom;
    logic [TPC_PRE_W-1:0] pre_mask;
    logic [15:0] cnt_next;
    tpc_dir_e dir_next;

    assign running = cfg_q.clk_src != TPC_CLK_OFF;
    assign ext_rise = ext_q & ~ext_prev_reg;
    assign src_tick = (cfg_q.clk_src == TPC_CLK_CNT) || ((cfg_q.clk_src == TPC_CLK_EXT) && ext_rise);
    assign pre_mask = TPC_PRE_W'((8'h01 << cfg_q.ps) - 8'h01);
    assign tick = src_tick && ((pre_reg & pre_mask) == pre_mask);
    assign cnt_wr = wr_tog_q ^ wr_prev_reg;
    assign at_lim = cnt_reg == act_lim_reg;
    assign wrap = tick && !cfg_q.center && at_lim;
    assign turn = tick && cfg_q.center && (dir_reg == TPC_DIR_UP) && at_lim;
    assign bottom = tick && cfg_q.center && (dir_reg == TPC_DIR_DOWN) && (cnt_reg == 16'h0000);
    assign cnt_next = !tick ? cnt_reg
                    : wrap ? 16'h0000
                    : (turn || (dir_reg == TPC_DIR_DOWN && !bottom)) ? cnt_reg - 16'h0001
                    : cnt_reg + 16'h0001;
    assign dir_next = turn ? TPC_DIR_DOWN
                    : (bottom || !cfg_q.center) ? TPC_DIR_UP
                    : dir_reg;

    always_ff @(posedge clk_cnt or posedge rst) begin
        if (rst) begin
            pre_reg <= '0;
            cnt_reg <= 16'h0000;
            dir_reg <= TPC_DIR_UP;
            act_lim_reg <= TPC_LIMIT_RST;
            ext_prev_reg <= 1'b0;
            wr_prev_reg <= 1'b0;
            ovf_tog_reg <= 1'b0;
        end else begin
            ext_prev_reg <= ext_q;
            wr_prev_reg <= wr_tog_q;
            ovf_tog_reg <= ovf_tog_reg ^ (!cnt_wr && (wrap || turn));
            if (!running || wrap || turn) begin
                act_lim_reg <= cfg_q.limit;
            end
            if (cnt_wr) begin
                pre_reg <= '0;
                cnt_reg <= 16'h0000;
                dir_reg <= TPC_DIR_UP;
            end else begin
                pre_reg <= src_tick ? pre_reg + 1'b1 : pre_reg;
                cnt_reg <= cnt_next;
                dir_reg <= dir_next;
            end
        end
    end

    // Per-channel logic in both domains.
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        tpc_chan_ctrl_s ctrl_reg;
        logic chf_reg;
        logic [15:0] cv_reg;
        logic irq_reg;
        logic wr_ctrl;
        logic wr_val;
        logic cap_bus;
        logic ev;
        logic clr;

        logic [15:0] act_cv_reg;
        logic [15:0] cap_val_reg;
        logic out_reg;
        logic oe_n_reg;
        logic oc_prev_reg;
        logic pin_prev_reg;
        logic tog_reg;
        logic is_cap;
        logic is_oc;
        logic is_edge_aligned_pwm;
        logic is_center_aligned_pwm;
        logic hi;
        logic edge_hit;
        logic match;
        logic over;
        logic cmp_ev;

        assign wr_ctrl = reg_wr && ch_hit && (ch_idx == 8'(g)) && !ch_is_val;
        assign wr_val = reg_wr && ch_hit && (ch_idx == 8'(g)) && ch_is_val;
        assign cap_bus = !center_align_select_reg && (ctrl_reg.fn == TPC_FN_CAPTURE)
                       && (ctrl_reg.els != TPC_ELS_NONE);
        assign ev = evt_q[g] ^ evt_seen_reg[g];
        assign clr = (wr_ctrl && reg_wdata[TPC_CH_FLAG_BIT]) || (reg_wr && sel_status && reg_wdata[g]);

        always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
                ctrl_reg <= '0;
                chf_reg <= 1'b0;
                cv_reg <= TPC_VALUE_RST;
                irq_reg <= 1'b0;
            end else begin
                if (wr_ctrl) begin
                    ctrl_reg <= '{irq_en: reg_wdata[TPC_CH_IE_BIT],
                                  fn: reg_wdata[TPC_CH_FN_LSB +: 2],
                                  els: reg_wdata[TPC_CH_ELS_LSB +: 2]};
                end
                chf_reg <= ev | (chf_reg & ~clr);
                // The captured word is stable here: it changed two bus clock edges earlier.
                if (ev && cap_bus) begin
                    cv_reg <= cap_val_reg;
                end else if (wr_val && !cap_bus) begin
                    cv_reg <= reg_wdata[15:0];
                end
                irq_reg <= chf_reg & ctrl_reg.irq_en;
            end
        end

        assign is_cap = !cfg_q.center && (chc_q[g].fn == TPC_FN_CAPTURE)
                      && (chc_q[g].els != TPC_ELS_NONE);
        assign is_oc = !cfg_q.center && (chc_q[g].fn == TPC_FN_COMPARE);
        assign is_edge_aligned_pwm = !cfg_q.center && (chc_q[g].fn == TPC_FN_PWM);
        assign is_center_aligned_pwm = cfg_q.center && (chc_q[g].fn == TPC_FN_PWM);
        assign hi = !chc_q[g].els[0];
        assign edge_hit = (chc_q[g].els[0] && pin_q[g] && !pin_prev_reg)
                        || (chc_q[g].els[1] && !pin_q[g] && pin_prev_reg);
        assign match = tick && !cnt_wr && (cnt_next == act_cv_reg);
        assign over = act_cv_reg > act_lim_reg;
        assign cmp_ev = ((is_oc || is_edge_aligned_pwm) && match)
                      || (is_center_aligned_pwm && (match || (turn && over)));

        always_ff @(posedge clk_cnt or posedge rst) begin
            if (rst) begin
                act_cv_reg <= TPC_VALUE_RST;
                cap_val_reg <= 16'h0000;
                out_reg <= 1'b0;
                oe_n_reg <= 1'b1;
                oc_prev_reg <= 1'b0;
                pin_prev_reg <= 1'b0;
                tog_reg <= 1'b0;
            end else begin
                pin_prev_reg <= pin_q[g];
                oc_prev_reg <= is_oc;
                oe_n_reg <= !((chc_q[g].els != TPC_ELS_NONE) && !is_cap);
                if (!running || (is_oc && tick) || (is_edge_aligned_pwm && wrap) || (is_center_aligned_pwm && turn)) begin
                    act_cv_reg <= cv_q[g];
                end
                // The detect reads the second sync stage, so this lands on the third edge.
                if (is_cap && edge_hit) begin
                    cap_val_reg <= cnt_reg;
                end
                tog_reg <= tog_reg ^ ((is_cap && edge_hit) || cmp_ev);
                if (cnt_wr && !is_oc) begin
                    out_reg <= 1'b0;
                end else if (is_oc && !oc_prev_reg) begin
                    out_reg <= chc_q[g].els == TPC_ELS_CLEAR;
                end else if (is_oc && match) begin
                    case (chc_q[g].els)
                        TPC_ELS_TOGGLE: out_reg <= ~out_reg;
                        TPC_ELS_CLEAR: out_reg <= 1'b0;
                        TPC_ELS_SET: out_reg <= 1'b1;
                        default: out_reg <= out_reg;
                    endcase
                end else if (is_edge_aligned_pwm && match) begin
                    out_reg <= ~hi;
                end else if (is_edge_aligned_pwm && wrap) begin
                    out_reg <= hi;
                end else if (is_center_aligned_pwm && match) begin
                    out_reg <= (dir_next == TPC_DIR_DOWN && act_cv_reg != 16'h0000) ? hi : ~hi;
                end else if (is_center_aligned_pwm && turn && over) begin
                    out_reg <= hi;
                end
            end
        end

        assign chc_w[g] = ctrl_reg;
        assign cv_w[g] = cv_reg;
        assign chf_w[g] = chf_reg;
        assign irq_w[g] = irq_reg;
        assign ch_tog_w[g] = tog_reg;
        assign out_w[g] = out_reg;
        assign oe_n_w[g] = oe_n_reg;
    end

    assign channel_irq = irq_w;
    assign channel_pin_out = out_w;
    assign channel_pin_oe_n = oe_n_w;
endmodule

// file: test/tpc_timer_asserts.sv
// Checker for the timer unit: register port, pin enables and interrupts.
// Assumes it is bound to tpc_timer and that modes change only while stopped.
`timescale 1ns/1ps
module tpc_timer_asserts #(
    parameter int NCH = 6
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_cnt,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ext_clk_pin,
    input wire logic [NCH-1:0] channel_pin_in,
    input wire logic [NCH-1:0] channel_pin_out,
    input wire logic [NCH-1:0] channel_pin_oe_n,
    input wire logic overflow_irq,
    input wire logic [NCH-1:0] channel_irq
);
    import tpc_pkg::*;
    logic ie_ovf_reg;
    logic [NCH-1:0] ie_reg;
    logic [NCH-1:0] drv_reg;
    logic clr_wr;
    logic hole_rd;
    assign clr_wr = reg_wr && (reg_addr == TPC_ADDR_SC || reg_addr == TPC_ADDR_STATUS
        || (reg_addr >= TPC_ADDR_CH_BASE && reg_addr[2:0] == 3'h0));
    assign hole_rd = reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr >= 8'(16 + 8 * NCH));
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ie_ovf_reg <= 1'b0;
            ie_reg <= '0;
            drv_reg <= '0;
        end else if (reg_wr) begin
            if (reg_addr == TPC_ADDR_SC) begin
                ie_ovf_reg <= reg_wdata[TPC_SC_OVERFLOW_IRQ_ENABLE_BIT];
            end
            for (int i = 0; i < NCH; i++) begin
                if (reg_addr == 8'(16 + 8 * i)) begin
                    ie_reg[i] <= reg_wdata[TPC_CH_IE_BIT];
                    drv_reg[i] <= reg_wdata[1:0] != 2'h0 && reg_wdata[3:2] != 2'h0;
                end
            end
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // Flags clear only by a write, and the interrupt trails the flag by one edge.
    sequence s_clr_seen;
        $past(clr_wr, 1) || $past(clr_wr, 2) || $past(clr_wr, 3);
    endsequence
    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_hole;
        hole_rd |=> reg_rdata == 32'h0;
    endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_status_w;
        reg_rd && reg_addr == TPC_ADDR_STATUS |=> reg_rdata[31:9] == '0 && reg_rdata[7:6] == '0;
    endproperty
    a_status_w: assert property (p_status_w) else $error("status spare bits set");
    property p_ovf_en;
        overflow_irq |-> $past(ie_ovf_reg);
    endproperty
    a_ovf_en: assert property (p_ovf_en) else $error("overflow irq while masked");
    property p_ch_en;
        (channel_irq & ~$past(ie_reg)) == '0;
    endproperty
    a_ch_en: assert property (p_ch_en) else $error("channel irq while masked");
    property p_ovf_clr;
        $fell(overflow_irq) |-> s_clr_seen;
    endproperty
    a_ovf_clr: assert property (p_ovf_clr) else $error("overflow irq dropped alone");
    property p_ch_clr;
        (~channel_irq & $past(channel_irq)) != '0 |-> s_clr_seen;
    endproperty
    a_ch_clr: assert property (p_ch_clr) else $error("channel irq dropped alone");
    property p_oe;
        (~channel_pin_oe_n & ~(drv_reg | $past(drv_reg, 4) | $past(drv_reg, 8))) == '0;
    endproperty
    a_oe: assert property (p_oe) else $error("pin driven without an edge mode");
endmodule

bind tpc_timer tpc_timer_asserts #(.NCH(NCH)) i_tpc_timer_asserts (.clk_sys(clk_sys),
    .rst(rst), .clk_cnt(clk_cnt), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk_pin),
    .channel_pin_in(channel_pin_in), .channel_pin_out(channel_pin_out),
    .channel_pin_oe_n(channel_pin_oe_n), .overflow_irq(overflow_irq),
    .channel_irq(channel_irq));

// file: test/tpc_pin_model.sv
// Far-side model: external clock source and capture pin drivers.
// Assumes the bench sets wanted pin levels; the model spaces the edges.
`timescale 1ns/1ps
module tpc_pin_model #(
    parameter int NCH = 6
) (
    input wire logic clk_cnt,
    input wire logic rst,
    input wire logic [NCH-1:0] level_req,
    output logic ext_clk_pin,
    output logic [NCH-1:0] channel_pin_in
);
    logic [1:0] div_reg;
    logic [1:0] hold_reg;
    // A quarter of the counter clock stays below half rate, with margin for jitter.
    assign ext_clk_pin = div_reg[1];
    always_ff @(posedge clk_cnt or posedge rst) begin
        if (rst) begin
            div_reg <= 2'h0;
            hold_reg <= 2'h0;
            channel_pin_in <= '0;
        end else begin
            div_reg <= div_reg + 2'h1;
            hold_reg <= hold_reg - 2'(hold_reg != 2'h0);
            // Pin edges stay four counter clocks apart.
            if (hold_reg == 2'h0 && channel_pin_in != level_req) begin
                channel_pin_in <= level_req;
                hold_reg <= 2'h3;
            end
        end
    end
endmodule

// file: test/tb_tpc_timer.sv
// Self-checking bench for the timer unit: bus tasks, pulse timing and register checks.
// Assumes the pin model on the far side and the checker bound to the design.
`timescale 1ns/1ps
module tb_tpc_timer;
    import tpc_pkg::*;
    logic clk_sys, clk_cnt, rst, reg_wr, reg_rd, ext_clk, ovf_irq;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d, c;
    logic [5:0] level_req, pin_in, pin_out, oe_n, ch_irq;
    int bad_count, checks_done, n;
    int unsigned tw[8][6] = '{
        '{8, 4, 10, 2, 2, 5}, // Up count, edge PWM.
        '{8, 4, 9, 2, 3, 5}, // Inverted polarity.
        '{10, 4, 10, 2, 8, 20}, // Divide by four.
        '{15, 1, 10, 1, 128, 256}, // Divide by 128.
        '{40, 4, 10, 1, 2, 8}, // Centre PWM, limit kept legal.
        '{40, 4, 9, 1, 6, 8}, // Centre PWM inverted.
        '{8, 9, 5, 3, 10, 20}, // Compare toggles on each match.
        '{16, 4, 10, 2, 8, 20} // External clock source.
    };
    int unsigned tf[4][6] = '{
        '{8, 4, 10, 0, 0, 1}, // Edge PWM at zero width.
        '{8, 4, 10, 5, 1, 0}, // Edge PWM beyond the limit never flags.
        '{40, 4, 10, 0, 0, 1}, // Centre PWM at zero width.
        '{40, 4, 10, 5, 1, 1} // Centre PWM beyond the limit flags at the turn.
    };
    tpc_timer #(.NCH(TPC_NCH)) i_tpc_timer (.clk_sys(clk_sys), .rst(rst), .clk_cnt(clk_cnt),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_clk_pin(ext_clk), .channel_pin_in(pin_in),
        .channel_pin_out(pin_out), .channel_pin_oe_n(oe_n), .overflow_irq(ovf_irq),
        .channel_irq(ch_irq));
    tpc_pin_model #(.NCH(TPC_NCH)) i_tpc_pin_model (.clk_cnt(clk_cnt), .rst(rst),
        .level_req(level_req), .ext_clk_pin(ext_clk), .channel_pin_in(pin_in));
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        clk_cnt = 1'b0;
        forever #8.5 clk_cnt = ~clk_cnt;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic chk_wave(input int hi, input int per, input int ehi, input int eper);
        checks_done++;
        if (hi != ehi || per != eper) begin
            bad_count++;
            $display("[FAIL] %0t pulse %0d of %0d expected %0d of %0d", $time, hi, per, ehi, eper);
        end
    endtask
    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            bad_count++;
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        v = reg_rdata;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(v, e);
    endtask
    // Modes change only with the counter stopped, since configuration crosses unhandshaked.
    task automatic setup(input logic [31:0] sc, input logic [31:0] lim, input logic [31:0] ctl,
            input logic [31:0] val);
        wr(TPC_ADDR_SC, sc & 32'hFFFF_FFE7);
        repeat (10) @(posedge clk_sys);
        wr(TPC_ADDR_MOD, lim);
        wr(TPC_ADDR_CH_BASE, ctl);
        wr(TPC_ADDR_CH_BASE + 8'h4, val);
        wr(TPC_ADDR_CNT, 32'h0);
        repeat (10) @(posedge clk_sys);
        wr(TPC_ADDR_SC, sc);
    endtask
    task automatic wave(input int ehi, input int eper);
        int hi, per, k;
        for (k = 0; k < 3000 && pin_out[0] !== 1'b0; k++) @(negedge clk_cnt);
        for (; k < 3000 && pin_out[0] !== 1'b1; k++) @(negedge clk_cnt);
        for (hi = 0; k < 3000 && pin_out[0] === 1'b1; k++, hi++) @(negedge clk_cnt);
        for (per = hi; k < 3000 && pin_out[0] === 1'b0; k++, per++) @(negedge clk_cnt);
        give_up(k, 3000);
        chk_wave(hi, per, ehi, eper);
        @(posedge clk_sys);
    endtask
    task automatic flat(input logic lvl);
        int k, miss;
        miss = 0;
        repeat (40) @(negedge clk_cnt);
        for (k = 0; k < 300; k++) begin
            @(negedge clk_cnt);
            miss += int'(pin_out[0] !== lvl);
        end
        chk(32'(miss), 32'h0);
        @(posedge clk_sys);
    endtask
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        level_req = 6'h00;
        bad_count = 0;
        checks_done = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdchk(TPC_ADDR_SC, 32'h0);
        rdchk(TPC_ADDR_STATUS, 32'h0);
        rdchk(TPC_ADDR_CH_BASE, 32'h0);
        rdchk(8'h71, 32'h0);
        chk({oe_n, pin_out, ch_irq, 7'h00, ovf_irq}, {6'h3F, 20'h0});
        foreach (tw[i]) begin
            setup(tw[i][0], tw[i][1], tw[i][2], tw[i][3]);
            wave(tw[i][4], tw[i][5]);
        end
        foreach (tf[i]) begin
            setup(tf[i][0], tf[i][1], tf[i][2], tf[i][3]);
            flat(tf[i][4] != 0);
            wr(TPC_ADDR_STATUS, 32'h3F);
            repeat (30) @(posedge clk_sys);
            rd(TPC_ADDR_STATUS, d);
            chk(d[0], tf[i][5] != 0);
        end
        setup(32'h0, 32'h9, 32'h6, 32'h3);
        repeat (10) @(posedge clk_sys);
        chk({oe_n[0], pin_out[0]}, 2'h1);
        setup(32'h48, 32'h0, 32'h0, 32'h0);
        for (n = 0; n < 200 && ovf_irq !== 1'b1; n++) @(posedge clk_sys);
        give_up(n, 200);
        wr(TPC_ADDR_STATUS, 32'h100);
        repeat (8) @(posedge clk_sys);
        rd(TPC_ADDR_STATUS, d);
        chk(d[8], 1'b1);
        wr(TPC_ADDR_SC, 32'h8);
        repeat (3) @(posedge clk_sys);
        chk(ovf_irq, 1'b0);
        wr(TPC_ADDR_SC, 32'h0);
        rd(TPC_ADDR_SC, d);
        chk(d[4:3] != 2'h0, 1'b1);
        for (n = 0; n < 20 && d[4:3] != 2'h0; n++) rd(TPC_ADDR_SC, d);
        chk(d[4:3], 2'h0);
        setup(32'hF, 32'hFFFF, 32'h41, 32'h0);
        repeat (300) @(posedge clk_sys);
        wr(TPC_ADDR_STATUS, 32'h3F);
        level_req <= 6'h01;
        for (n = 0; n < 40 && d[0] !== 1'b1; n++) rd(TPC_ADDR_STATUS, d);
        give_up(n, 40);
        rdchk(TPC_ADDR_CH_BASE, 32'hC1);
        chk(ch_irq[0], 1'b1);
        rd(TPC_ADDR_CH_BASE + 8'h4, d);
        rd(TPC_ADDR_CNT, c);
        chk(c - d + 32'h1 <= 32'h2, 1'b1);
        wr(TPC_ADDR_CH_BASE + 8'h4, 32'h1234);
        rdchk(TPC_ADDR_CH_BASE + 8'h4, d);
        wr(TPC_ADDR_STATUS, 32'h1);
        repeat (4) @(posedge clk_sys);
        chk(ch_irq[0], 1'b0);
        wr(TPC_ADDR_SC, 32'h7);
        repeat (20) @(posedge clk_sys);
        rd(TPC_ADDR_CNT, c);
        chk(c != 32'h0, 1'b1);
        repeat (300) @(posedge clk_sys);
        rdchk(TPC_ADDR_CNT, c);
        wr(TPC_ADDR_CNT, 32'h5);
        repeat (20) @(posedge clk_sys);
        rdchk(TPC_ADDR_CNT, 32'h0);
        final_report();
    end
endmodule
